// ### adcpk_top.sv
// Purpose: Serial control port, ADC mode settings and clear-on-read peak detectors.
// Assumes: All pins synchronous to clock; control clock far slower than clock.
// Notes: Read data is returned in the transaction that follows the read command.
// Notes: Writes that arrive while the internal clear runs are dropped, not queued.
// Notes: Peaks of the secondary pair stop tracking while the 96 kHz rate is selected; a read still clears them.
`include "adcpk_params.svh"
`timescale 1ns/100ps
`default_nettype none
module adcpk_top
    import adcpk_pkg::*;
(
    input wire logic clock, // 100 MHz system clock
    input wire logic rst_n, // Power-down reset pin, active low
    input wire logic ctl_sclk, // Control serial clock
    input wire logic ctl_sdi, // Control serial data in
    input wire logic ctl_latch_n, // Control word frame, active low
    output logic ctl_sdo, // Control serial data out
    output logic ctl_sdo_oe, // Serial out drive enable
    input wire logic frame_tick, // One pulse per sample frame
    input wire logic [3:0][9:0] level_in, // Per-channel level, 60 = 0 dB
    input wire logic [3:0] level_valid, // Level strobe per channel
    output adcpk_cfg_s cfg_q, // Current ADC settings
    output logic [7:0] osr_q, // Decimation ratio
    output logic secondary_en_q, // Secondary pair converting
    output logic init_busy_q // Internal clear running
);
    logic sclk_prev_q;
    logic latch_prev_q;
    logic [15:0] in_q;
    logic [15:0] in_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [15:0] out_q;
    logic [15:0] out_d;
    logic sdo_d;
    logic [4:0] init_q;
    logic [4:0] init_d;
    adcpk_cfg_s cfg_d;
    adcpk_peak_t peak_q [4];
    adcpk_peak_t peak_d [4];

    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;
    logic cmd_ok;
    logic cmd_read;
    logic [3:0] cmd_addr;
    logic [9:0] cmd_data;
    logic [3:0] rd_clear;
    logic [9:0] rd_val;
    logic busy;
    logic [7:0] osr_d;
    logic sec_en_d;
    logic busy_d;
    logic sdo_oe_d;

    // Edge detect on sampled pins; reset values match the idle levels
    assign sclk_rise = ctl_sclk & ~sclk_prev_q & ~ctl_latch_n;
    assign sclk_fall = ~ctl_sclk & sclk_prev_q & ~ctl_latch_n;
    assign frame_start = ~ctl_latch_n & latch_prev_q;
    assign frame_end = ctl_latch_n & ~latch_prev_q;
    assign cmd_ok = frame_end && (cnt_q == `ADCPK_WORD_BITS);
    assign cmd_read = in_q[`ADCPK_RNW_BIT];
    assign cmd_addr = in_q[`ADCPK_ADDR_MSB:`ADCPK_ADDR_LSB];
    assign cmd_data = in_q[`ADCPK_DATA_MSB:0];
    assign busy = (init_q != 5'h00);

    // Serial shifting and command decode
    always_comb begin
        in_d = in_q;
        cnt_d = cnt_q;
        out_d = out_q;
        sdo_d = ctl_sdo;
        rd_clear = 4'h0;
        rd_val = 10'h000;
        if (frame_start) begin
            cnt_d = 5'h00;
            sdo_d = out_q[15];
            out_d = {out_q[14:0], 1'b0};
        end else if (sclk_rise && cnt_q != `ADCPK_WORD_BITS) begin
            // Bits past sixteen are ignored, so a long frame acts on its first sixteen bits
            in_d = {in_q[14:0], ctl_sdi};
            cnt_d = cnt_q + 5'h01;
        end else if (sclk_fall) begin
            sdo_d = out_q[15];
            out_d = {out_q[14:0], 1'b0};
        end
        if (cmd_ok && cmd_read) begin
            unique case (cmd_addr)
                `ADCPK_ADDR_CTRL1: begin
                    rd_val[`ADCPK_CTRL1_RATE_BIT] = cfg_q.rate96;
                    rd_val[`ADCPK_CTRL1_BUSY_BIT] = busy;
                end
                `ADCPK_ADDR_CTRL3: begin
                    rd_val[`ADCPK_CTRL3_MODE_LSB +: 2] = cfg_q.mode;
                    rd_val[`ADCPK_CTRL3_GL_LSB +: 3] = cfg_q.gain_l;
                    rd_val[`ADCPK_CTRL3_GR_LSB +: 3] = cfg_q.gain_r;
                    rd_val[`ADCPK_CTRL3_MUX_BIT] = cfg_q.mux_sel;
                end
                default: begin
                    if (cmd_addr >= `ADCPK_ADDR_PEAK0) begin
                        rd_val = peak_q[cmd_addr[1:0]];
                        rd_clear[cmd_addr[1:0]] = 1'b1;
                    end
                end
            endcase
            // Read data goes back in the next frame, upper bits zero
            out_d = {6'h00, rd_val};
        end
    end

    // Control registers
    always_comb begin
        cfg_d = cfg_q;
        if (cmd_ok && !cmd_read && !busy) begin
            if (cmd_addr == `ADCPK_ADDR_CTRL1) begin
                cfg_d.rate96 = cmd_data[`ADCPK_CTRL1_RATE_BIT];
            end else if (cmd_addr == `ADCPK_ADDR_CTRL3) begin
                // Illegal mode code keeps the old mode
                if (cmd_data[`ADCPK_CTRL3_MODE_LSB +: 2] != 2'h3) begin
                    cfg_d.mode = adcpk_mode_e'(cmd_data[`ADCPK_CTRL3_MODE_LSB +: 2]);
                end
                // Gain codes above 12 dB saturate
                if (cmd_data[`ADCPK_CTRL3_GL_LSB +: 3] > `ADCPK_GAIN_MAX) begin
                    cfg_d.gain_l = `ADCPK_GAIN_MAX;
                end else begin
                    cfg_d.gain_l = cmd_data[`ADCPK_CTRL3_GL_LSB +: 3];
                end
                if (cmd_data[`ADCPK_CTRL3_GR_LSB +: 3] > `ADCPK_GAIN_MAX) begin
                    cfg_d.gain_r = `ADCPK_GAIN_MAX;
                end else begin
                    cfg_d.gain_r = cmd_data[`ADCPK_CTRL3_GR_LSB +: 3];
                end
                cfg_d.mux_sel = cmd_data[`ADCPK_CTRL3_MUX_BIT];
            end
        end
        init_d = init_q;
        if (frame_tick && busy) begin
            init_d = init_q - 5'h01;
        end
        busy_d = (init_d != 5'h00);
        // Ratio and pair enable follow the rate bit in the same cycle as cfg
        osr_d = cfg_d.rate96 ? `ADCPK_OSR_96K : `ADCPK_OSR_48K;
        sec_en_d = ~cfg_d.rate96;
        sdo_oe_d = ~ctl_latch_n;
    end

    // Peak detectors
    always_comb begin
        adcpk_peak_t lvl;
        logic active;
        lvl = `ADCPK_PEAK_ZERO;
        active = 1'b0;
        for (int ch = 0; ch < 4; ch++) begin
            peak_d[ch] = peak_q[ch];
            lvl = (level_in[ch] > `ADCPK_PEAK_MAX) ? `ADCPK_PEAK_MAX : level_in[ch];
            active = level_valid[ch] && !busy && (ch < 2 || !cfg_q.rate96);
            if (busy) begin
                peak_d[ch] = `ADCPK_PEAK_ZERO;
            end else if (rd_clear[ch]) begin
                // A strobe in the clear cycle wins so no sample is lost
                peak_d[ch] = active ? lvl : `ADCPK_PEAK_ZERO;
            end else if (active && lvl > peak_q[ch]) begin
                peak_d[ch] = lvl;
            end
        end
    end

    // State registers only; next values come from the blocks above, edge samples straight from the pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
            latch_prev_q <= 1'b1;
            in_q <= 16'h0000;
            cnt_q <= 5'h00;
            out_q <= 16'h0000;
            ctl_sdo <= 1'b0;
            ctl_sdo_oe <= 1'b0;
            init_q <= `ADCPK_INIT_FRAMES;
            init_busy_q <= 1'b1;
            cfg_q <= '{
                rate96: 1'b0,
                mode: ADCPK_MODE_DIRECT,
                gain_l: 3'h0,
                gain_r: 3'h0,
                mux_sel: 1'b0
            };
            osr_q <= `ADCPK_OSR_48K;
            secondary_en_q <= 1'b1;
            for (int ch = 0; ch < 4; ch++) begin
                peak_q[ch] <= `ADCPK_PEAK_ZERO;
            end
        end else begin
            sclk_prev_q <= ctl_sclk;
            latch_prev_q <= ctl_latch_n;
            in_q <= in_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            ctl_sdo <= sdo_d;
            ctl_sdo_oe <= sdo_oe_d;
            init_q <= init_d;
            init_busy_q <= busy_d;
            cfg_q <= cfg_d;
            osr_q <= osr_d;
            secondary_en_q <= sec_en_d;
            for (int ch = 0; ch < 4; ch++) begin
                peak_q[ch] <= peak_d[ch];
            end
        end
    end
endmodule : adcpk_top
`default_nettype wire

// ### adcpk_params.svh
// Purpose: Constants for the ADC mode control and peak readback block.
// Assumes: 100 MHz system clock; control port pins sampled synchronously.
// Notes: Control word is addr[15:12], read flag [11], spare [10], data [9:0].
`ifndef ADCPK_PARAMS_SVH
`define ADCPK_PARAMS_SVH

`define ADCPK_WORD_BITS 5'h10
`define ADCPK_ADDR_MSB 15
`define ADCPK_ADDR_LSB 12
`define ADCPK_RNW_BIT 11
`define ADCPK_DATA_MSB 9

`define ADCPK_ADDR_CTRL1 4'h8
`define ADCPK_ADDR_CTRL3 4'hA
`define ADCPK_ADDR_PEAK0 4'hC
`define ADCPK_ADDR_PEAK3 4'hF

`define ADCPK_CTRL1_RATE_BIT 0
`define ADCPK_CTRL1_BUSY_BIT 9
`define ADCPK_CTRL3_MODE_LSB 0
`define ADCPK_CTRL3_GL_LSB 2
`define ADCPK_CTRL3_GR_LSB 5
`define ADCPK_CTRL3_MUX_BIT 8

`define ADCPK_GAIN_MAX 3'h4
`define ADCPK_PEAK_MAX 10'h03C
`define ADCPK_PEAK_ZERO 10'h000
`define ADCPK_OSR_48K 8'h80
`define ADCPK_OSR_96K 8'h40
`define ADCPK_INIT_FRAMES 5'h14
`define ADCPK_SCLK_MAX_HZ 8000000
`define ADCPK_CLK_HZ 100000000

`endif

// ### adcpk_pkg.sv
// Purpose: Types for the ADC mode control and peak readback block.
// Assumes: Constants come from adcpk_params.svh.
// Notes: Mode code 2'b11 is illegal and is never stored.
package adcpk_pkg;
    typedef enum logic [1:0] {
        ADCPK_MODE_DIRECT = 2'b00,
        ADCPK_MODE_PGA_DIFF = 2'b01,
        ADCPK_MODE_MUX_PGA = 2'b10
    } adcpk_mode_e;

    typedef struct packed {
        logic rate96;
        adcpk_mode_e mode;
        logic [2:0] gain_l;
        logic [2:0] gain_r;
        logic mux_sel;
    } adcpk_cfg_s;

    typedef logic [9:0] adcpk_peak_t;
endpackage : adcpk_pkg

// ### adcpk_checker.sv
// Purpose: Port checks for adcpk_top
// Assumes: One clock, rst_n async
// Notes: Bound after the module
`timescale 1ns/100ps
`default_nettype none
module adcpk_checker
    import adcpk_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rst_n, // Reset
    input wire logic ctl_latch_n, // Frame
    input wire logic ctl_sdo, // Serial out
    input wire logic ctl_sdo_oe, // Out enable
    input wire logic frame_tick, // Frame pulse
    input wire adcpk_cfg_s cfg_q, // Settings
    input wire logic [7:0] osr_q, // Ratio
    input wire logic secondary_en_q, // Pair on
    input wire logic init_busy_q // Clearing
);
    logic [4:0] ticks_q, ticks_d;
    always_comb begin
        ticks_d = ticks_q;
        if (frame_tick && ticks_q < 5'h14) ticks_d = ticks_q + 5'h01;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) ticks_q <= 5'h00;
        else ticks_q <= ticks_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence open_s; $fell(ctl_latch_n); endsequence
    sequence close_s; $rose(ctl_latch_n); endsequence
    osr_ratio_a: assert property (osr_q == (cfg_q.rate96 ? 8'h40 : 8'h80)) else $error("bad ratio");
    pair_off_a: assert property (secondary_en_q == !cfg_q.rate96) else $error("bad pair");
    mode_legal_a: assert property (cfg_q.mode != 2'h3) else $error("bad mode");
    gain_range_a: assert property (cfg_q.gain_l <= 3'h4 && cfg_q.gain_r <= 3'h4) else $error("bad gain");
    busy_span_a: assert property (init_busy_q == (ticks_q < 5'h14)) else $error("bad busy");
    busy_frozen_a: assert property (init_busy_q |=> $stable(cfg_q)) else $error("write in busy");
    oe_open_a: assert property (open_s |=> ctl_sdo_oe) else $error("no drive");
    oe_close_a: assert property (close_s |=> !ctl_sdo_oe) else $error("drive kept");
    msb_zero_a: assert property (open_s |=> !ctl_sdo) else $error("bad msb");
endmodule : adcpk_checker
bind adcpk_top adcpk_checker u_chk (.*);
`default_nettype wire

// ### adcpk_host.sv
// Purpose: Host on the control port
// Assumes: Called from the bench
// Notes: Clock still between frames
`timescale 1ns/100ps
`default_nettype none
module adcpk_host (
    input wire logic clock, // Clock
    input wire logic ctl_sdo, // Data in
    output logic ctl_sclk, // Serial clock
    output logic ctl_sdi, // Data out
    output logic ctl_latch_n // Frame
);
    initial begin
        ctl_sclk = 1'b0;
        ctl_sdi = 1'b0;
        ctl_latch_n = 1'b1;
    end
    // One 16-bit word each way at 7.1 MHz
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge clock);
        ctl_latch_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ctl_sdi = w[i];
            repeat (7) @(negedge clock);
            ctl_sclk = 1'b1;
            r[i] = ctl_sdo;
            repeat (7) @(negedge clock);
            ctl_sclk = 1'b0;
        end
        repeat (7) @(negedge clock);
        ctl_latch_n = 1'b1;
        ctl_sdi = ~ctl_sdi;
        repeat (3) @(negedge clock);
    endtask : xfer
endmodule : adcpk_host
`default_nettype wire

// ### adcpk_tb_top.sv
// Purpose: Bench for adcpk_top
// Assumes: Inputs change at negedge
// Notes: Seed 40751
`timescale 1ns/100ps
`default_nettype none
module adcpk_tb_top
    import adcpk_pkg::*;
;
    logic clock = 1'b0, rst_n = 1'b0, frame_tick = 1'b0;
    logic [3:0][9:0] level_in = '0;
    logic [3:0] level_valid = 4'h0;
    wire logic ctl_sclk, ctl_sdi, ctl_latch_n, ctl_sdo, ctl_sdo_oe, sec_en, busy;
    adcpk_cfg_s cfg;
    logic [7:0] osr;
    int err_total = 0, tests_run = 0;
    logic [31:0] rng = 32'h00009F2F;
    logic [9:0] pk [4], ecfg, lv;
    logic [15:0] rd;
    logic [1:0] m;
    always #5 clock = ~clock;
    adcpk_top DUT (.clock(clock), .rst_n(rst_n), .ctl_sclk(ctl_sclk), .ctl_sdi(ctl_sdi),
        .ctl_latch_n(ctl_latch_n), .ctl_sdo(ctl_sdo), .ctl_sdo_oe(ctl_sdo_oe), .frame_tick(frame_tick),
        .level_in(level_in), .level_valid(level_valid), .cfg_q(cfg), .osr_q(osr),
        .secondary_en_q(sec_en), .init_busy_q(busy));
    adcpk_host host (.clock(clock), .ctl_sdo(ctl_sdo), .ctl_sclk(ctl_sclk), .ctl_sdi(ctl_sdi),
        .ctl_latch_n(ctl_latch_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [9:0] cfg_exp(input logic [9:0] d, input logic [1:0] p);
        if (d[1:0] != 2'h3) p = d[1:0];
        return {1'b0, p, (d[4:2] > 3'h4 ? 3'h4 : d[4:2]), (d[7:5] > 3'h4 ? 3'h4 : d[7:5]), d[8]};
    endfunction : cfg_exp
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        #300000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        chk({6'h00, cfg}, 16'h0000);
        chk({osr, 6'h00, busy, sec_en}, 16'h8003);
        host.xfer(16'hA001, rd);
        chk({6'h00, cfg}, 16'h0000);
        repeat (20) begin
            frame_tick = 1'b1;
            @(negedge clock);
            frame_tick = 1'b0;
            @(negedge clock);
        end
        chk({15'h0000, busy}, 16'h0000);
        $display("test reset done");
        m = 2'h0;
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            if (i < 4) rng[1:0] = i[1:0];
            host.xfer({4'hA, 2'h0, rng[9:0]}, rd);
            ecfg = cfg_exp(rng[9:0], m);
            m = ecfg[8:7];
            chk({6'h00, cfg}, {6'h00, ecfg});
        end
        $display("test config done");
        for (int p = 0; p < 2; p++) begin
            host.xfer({15'h4000, p[0]} << 1 >> 1 | 16'h8000, rd);
            chk({osr, 7'h00, sec_en}, p ? 16'h4000 : 16'h8001);
            pk = '{default: 10'h000};
            repeat (24) begin
                rng = xs(rng);
                level_in[rng[9:8]] = {3'h0, rng[6:0]};
                level_valid[rng[9:8]] = 1'b1;
                lv = rng[6:0] > 7'h3C ? 10'h03C : {3'h0, rng[6:0]};
                if ((p == 0 || !rng[9]) && lv > pk[rng[9:8]]) pk[rng[9:8]] = lv;
                @(negedge clock);
                level_valid = 4'h0;
            end
            for (int k = 0; k < 2; k++) begin
                host.xfer(16'hC800, rd);
                for (int c = 1; c < 5; c++) begin
                    host.xfer(c < 4 ? {4'hC + c[3:0], 12'h800} : 16'h0800, rd);
                    chk(rd, k ? 16'h0000 : {6'h00, pk[c-1]});
                end
            end
        end
        $display("test peaks done");
        stop_test();
    end
endmodule : adcpk_tb_top
`default_nettype wire
